// ### design/ssm_regs.svh
`ifndef SSM_REGS_SVH
`define SSM_REGS_SVH
// ==========================================================
// Register offsets
`define SSM_OFS_EVENT      8'h00
`define SSM_OFS_MASK       8'h04
`define SSM_OFS_STATE      8'h08
`define SSM_OFS_FORCE      8'h0C
// ==========================================================
// Mask fields
`define SSM_MSK_PWR        3
`define SSM_MSK_CD_HI      2
`define SSM_MSK_CD_LO      1
`define SSM_MSK_STS        0
`define SSM_MASK_RESET     4'h0
// ==========================================================
// Present state fields
`define SSM_ST_Y_SOCK      31
`define SSM_ST_X_SOCK      30
`define SSM_ST_3V3_SOCK    29
`define SSM_ST_5V_SOCK     28
`define SSM_ST_CARD_HI     13
`define SSM_ST_CARD_LO     10
`define SSM_ST_BADVCC      9
`define SSM_ST_DLOST       8
`define SSM_ST_PWR         3
`define SSM_ST_CD2         2
`define SSM_ST_CD1         1
`define SSM_ST_STS         0
// Force register bits
`define SSM_FRC_CVSTEST    14
`define SSM_FRC_BADVCC     9
`define SSM_FRC_DLOST      8
// Event bits
`define SSM_EV_PWR         3
`define SSM_EV_CD2         2
`define SSM_EV_CD1         1
`define SSM_EV_STS         0
`endif

// ### design/ssm_pkg.sv
package ssm_pkg;
  typedef struct packed {
    logic       sel;
    logic       wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ssm_req_t;

  typedef struct packed {
    logic cd1_n;
    logic cd2_n;
    logic sts_chg;
    logic powered;
    logic interrogating;
    logic cardbus;
    logic [3:0] card_volts;
    logic bad_vcc;
    logic data_lost;
  } ssm_sock_t;
endpackage

// ### design/ssm_event_edge.sv
`include "ssm_regs.svh"
module ssm_event_edge
  import ssm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sig,
  input  wire logic       both_edges,
  output logic            change
);
  logic prev_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= sig;
    end
  end

  // Rising only for CardBus, both edges for 16-bit cards
  assign change = both_edges ? (sig ^ prev_reg) : (sig & ~prev_reg);
endmodule // ssm_event_edge

// ### design/ssm_socket_regs.sv
`include "ssm_regs.svh"
module ssm_socket_regs
  import ssm_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        GLOBAL_RESET_IN_N,
  input  wire logic        PCI_BUS_RESET_IN_N,
  input  wire logic        PME_ENABLE,
  input  wire logic        SOCKET_5V_OVERRIDE,
  input  wire ssm_req_t    REQ,
  input  wire ssm_sock_t   SOCK,
  output logic [31:0]      RDATA,
  output logic             SOCKET_CHANGE_INTERRUPT
);
  // ==========================================================
  // Reset and input synchronisers
  logic [1:0]  rst_sync_reg;
  logic        rst_n;
  logic [1:0]  global_reset_in_sync_reg;
  logic [1:0]  pci_bus_reset_in_sync_reg;
  logic [1:0]  pme_sync_reg;
  logic [1:0]  ovr_sync_reg;
  logic [11:0] sock_s1_reg;
  logic [11:0] sock_s2_reg;
  ssm_sock_t   sock;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      global_reset_in_sync_reg <= 2'h3;
      pci_bus_reset_in_sync_reg <= 2'h3;
      pme_sync_reg  <= 2'h0;
      ovr_sync_reg  <= 2'h0;
      // Idle as an empty socket: both detect lines high, no flags raised
      sock_s1_reg   <= 12'hC00;
      sock_s2_reg   <= 12'hC00;
    end else begin
      global_reset_in_sync_reg <= {global_reset_in_sync_reg[0], GLOBAL_RESET_IN_N};
      pci_bus_reset_in_sync_reg <= {pci_bus_reset_in_sync_reg[0], PCI_BUS_RESET_IN_N};
      pme_sync_reg  <= {pme_sync_reg[0], PME_ENABLE};
      ovr_sync_reg  <= {ovr_sync_reg[0], SOCKET_5V_OVERRIDE};
      sock_s1_reg   <= SOCK;
      sock_s2_reg   <= sock_s1_reg;
    end
  end
  assign sock = ssm_sock_t'(sock_s2_reg);

  // Context bits survive a bus reset while PME is on
  logic ctx_clear;
  assign ctx_clear = !global_reset_in_sync_reg[1] || (!pci_bus_reset_in_sync_reg[1] && !pme_sync_reg[1]);

  // ==========================================================
  // Register decode
  logic wr_mask, wr_event, wr_force;
  assign wr_mask  = REQ.sel && REQ.wr && REQ.addr == `SSM_OFS_MASK;
  assign wr_event = REQ.sel && REQ.wr && REQ.addr == `SSM_OFS_EVENT;
  assign wr_force = REQ.sel && REQ.wr && REQ.addr == `SSM_OFS_FORCE;

  // ==========================================================
  // Mask register
  logic [3:0] mask_reg;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= `SSM_MASK_RESET;
    end else if (ctx_clear) begin
      mask_reg <= `SSM_MASK_RESET;
    end else if (wr_mask) begin
      mask_reg <= REQ.wdata[3:0];
    end
  end

  // ==========================================================
  // Live state with detect lines frozen during interrogation
  logic cd1_reg, cd2_reg, powered_reg, sts_reg;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cd1_reg     <= 1'b1;
      cd2_reg     <= 1'b1;
      powered_reg <= 1'b0;
      sts_reg     <= 1'b0;
    end else begin
      if (!sock.interrogating) begin
        cd1_reg <= sock.cd1_n;
        cd2_reg <= sock.cd2_n;
      end
      powered_reg <= sock.powered;
      sts_reg     <= sock.sts_chg;
    end
  end

  // ==========================================================
  // Insertion capture and forced fields
  logic       inserted, was_in_reg, cardbus_reg;
  logic [3:0] card_v_reg;
  logic       badvcc_reg, dlost_reg;
  logic [1:0] sock_ov_reg;
  assign inserted = !cd1_reg && !cd2_reg;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      was_in_reg  <= 1'b0;
      cardbus_reg <= 1'b0;
      card_v_reg  <= 4'h0;
    end else begin
      was_in_reg <= inserted;
      if (ctx_clear) begin
        card_v_reg  <= 4'h0;
        cardbus_reg <= 1'b0;
      end else if (wr_force && REQ.wdata[`SSM_FRC_CVSTEST]) begin
        card_v_reg  <= sock.card_volts;
        cardbus_reg <= sock.cardbus;
      end else if (inserted && !was_in_reg) begin
        card_v_reg  <= sock.card_volts;
        cardbus_reg <= sock.cardbus;
      end else if (wr_force) begin
        card_v_reg <= card_v_reg | REQ.wdata[`SSM_ST_CARD_HI:`SSM_ST_CARD_LO];
      end
    end
  end

  // Hardware set wins over a force write of zero
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      badvcc_reg  <= 1'b0;
      dlost_reg   <= 1'b0;
      sock_ov_reg <= 2'h0;
    end else if (ctx_clear) begin
      badvcc_reg <= 1'b0;
      dlost_reg  <= 1'b0;
    end else begin
      if (sock.bad_vcc) begin
        badvcc_reg <= 1'b1;
      end else if (wr_force) begin
        badvcc_reg <= REQ.wdata[`SSM_FRC_BADVCC];
      end
      if (sock.data_lost) begin
        dlost_reg <= 1'b1;
      end else if (wr_force) begin
        dlost_reg <= REQ.wdata[`SSM_FRC_DLOST];
      end
      if (wr_force) begin
        sock_ov_reg <= REQ.wdata[`SSM_ST_Y_SOCK:`SSM_ST_X_SOCK];
      end
    end
  end

  // ==========================================================
  // Event detection and event register
  logic sts_change;
  ssm_event_edge u_sts_edge (
    .clk        (CLK),
    .rst_n      (rst_n),
    .sig        (sts_reg),
    .both_edges (!cardbus_reg),
    .change     (sts_change)
  );

  logic       pwr_prev_reg, cd1_prev_reg, cd2_prev_reg;
  logic [3:0] ev_set, ev_clr, event_reg;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pwr_prev_reg <= 1'b0;
      cd1_prev_reg <= 1'b1;
      cd2_prev_reg <= 1'b1;
    end else begin
      pwr_prev_reg <= powered_reg;
      cd1_prev_reg <= cd1_reg;
      cd2_prev_reg <= cd2_reg;
    end
  end

  // Mask plays no part in setting
  assign ev_set = {powered_reg ^ pwr_prev_reg, cd2_reg ^ cd2_prev_reg,
                   cd1_reg ^ cd1_prev_reg, sts_change};
  assign ev_clr = wr_event ? REQ.wdata[3:0] : 4'h0;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      event_reg <= 4'h0;
    end else if (ctx_clear) begin
      event_reg <= 4'h0;
    end else begin
      event_reg <= (event_reg & ~ev_clr) | ev_set;
    end
  end

  // ==========================================================
  // Interrupt
  function automatic logic irq_of(input logic [3:0] ev, input logic [3:0] m);
    logic cd_en;
    cd_en  = m[`SSM_MSK_CD_HI] & m[`SSM_MSK_CD_LO];
    irq_of = (ev[`SSM_EV_PWR] & m[`SSM_MSK_PWR])
           | ((ev[`SSM_EV_CD2] | ev[`SSM_EV_CD1]) & cd_en)
           | (ev[`SSM_EV_STS] & m[`SSM_MSK_STS]);
  endfunction

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      SOCKET_CHANGE_INTERRUPT <= 1'b0;
    end else begin
      SOCKET_CHANGE_INTERRUPT <= irq_of(event_reg, mask_reg);
    end
  end

  // ==========================================================
  // Read data
  logic [31:0] state_word, rdata_next;
  always_comb begin
    state_word = 32'h0000_0000;
    state_word[`SSM_ST_Y_SOCK]   = sock_ov_reg[1];
    state_word[`SSM_ST_X_SOCK]   = sock_ov_reg[0];
    state_word[`SSM_ST_3V3_SOCK] = 1'b1;
    state_word[`SSM_ST_5V_SOCK]  = !ovr_sync_reg[1];
    state_word[`SSM_ST_CARD_HI:`SSM_ST_CARD_LO] = card_v_reg;
    state_word[`SSM_ST_BADVCC]   = badvcc_reg;
    state_word[`SSM_ST_DLOST]    = dlost_reg;
    state_word[5]                = cardbus_reg;
    state_word[4]                = inserted && !cardbus_reg;
    state_word[`SSM_ST_PWR]      = powered_reg;
    state_word[`SSM_ST_CD2]      = cd2_reg;
    state_word[`SSM_ST_CD1]      = cd1_reg;
    state_word[`SSM_ST_STS]      = sts_reg;
    unique case (REQ.addr)
      `SSM_OFS_EVENT: rdata_next = {28'h000_0000, event_reg};
      `SSM_OFS_MASK:  rdata_next = {28'h000_0000, mask_reg};
      `SSM_OFS_STATE: rdata_next = state_word;
      default:        rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 32'h0000_0000;
    end else if (REQ.sel && !REQ.wr) begin
      RDATA <= rdata_next;
    end
  end

  // ==========================================================
  // Checks
  AST_EVT_SETS: assert property (@(posedge CLK) disable iff (!rst_n)
    (powered_reg != pwr_prev_reg) && !ctx_clear |=> event_reg[`SSM_EV_PWR])
    else $error("power event not set");
  AST_MASK_HI: assert property (@(posedge CLK) disable iff (!rst_n)
    REQ.sel && !REQ.wr && REQ.addr == `SSM_OFS_MASK |=> RDATA[31:4] == 28'h000_0000)
    else $error("mask upper bits not zero");
  AST_CD_RSVD: assert property (@(posedge CLK) disable iff (!rst_n)
    mask_reg == 4'h2 && event_reg[`SSM_EV_PWR] == 1'b0 && event_reg[`SSM_EV_STS] == 1'b0
      |=> !SOCKET_CHANGE_INTERRUPT)
    else $error("reserved detect code enabled irq");
  AST_IRQ_PWR: assert property (@(posedge CLK) disable iff (!rst_n)
    event_reg[`SSM_EV_PWR] && mask_reg[`SSM_MSK_PWR] |=> SOCKET_CHANGE_INTERRUPT)
    else $error("power irq missing");
  AST_IRQ_STS: assert property (@(posedge CLK) disable iff (!rst_n)
    event_reg[`SSM_EV_STS] && mask_reg[`SSM_MSK_STS] |=> SOCKET_CHANGE_INTERRUPT)
    else $error("status irq missing");
  AST_CTX_CLR: assert property (@(posedge CLK) disable iff (!rst_n)
    ctx_clear |=> mask_reg == 4'h0 && event_reg == 4'h0)
    else $error("context not cleared");
  AST_FREEZE: assert property (@(posedge CLK) disable iff (!rst_n)
    sock.interrogating |=> $stable(cd1_reg) && $stable(cd2_reg))
    else $error("detect changed in interrogation");
  AST_W1C: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_event && REQ.wdata[`SSM_EV_CD1] && !ev_set[`SSM_EV_CD1] |=> !event_reg[`SSM_EV_CD1])
    else $error("write one did not clear");
  AST_3V3: assert property (@(posedge CLK) disable iff (!rst_n)
    REQ.sel && !REQ.wr && REQ.addr == `SSM_OFS_STATE |=> RDATA[`SSM_ST_3V3_SOCK])
    else $error("3v3 capability not one");
  AST_MASK_WR: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_mask && !ctx_clear |=> mask_reg == $past(REQ.wdata[3:0]))
    else $error("mask write not taken");
  AST_CD_EN: assert property (@(posedge CLK) disable iff (!rst_n)
    event_reg[`SSM_EV_CD1] && mask_reg[`SSM_MSK_CD_HI] && mask_reg[`SSM_MSK_CD_LO] |=> SOCKET_CHANGE_INTERRUPT)
    else $error("detect irq missing");
  AST_CD_RSVD_HI: assert property (@(posedge CLK) disable iff (!rst_n)
    mask_reg == 4'h4 && !event_reg[`SSM_EV_PWR] && !event_reg[`SSM_EV_STS] |=> !SOCKET_CHANGE_INTERRUPT)
    else $error("reserved detect code enabled irq");
  AST_MASK_OFF: assert property (@(posedge CLK) disable iff (!rst_n)
    mask_reg == 4'h0 |=> !SOCKET_CHANGE_INTERRUPT)
    else $error("irq with all masks off");
  AST_NO_EVT: assert property (@(posedge CLK) disable iff (!rst_n)
    event_reg == 4'h0 |=> !SOCKET_CHANGE_INTERRUPT)
    else $error("irq without event");
  AST_5V: assert property (@(posedge CLK) disable iff (!rst_n)
    REQ.sel && !REQ.wr && REQ.addr == `SSM_OFS_STATE && !ovr_sync_reg[1] |=> RDATA[`SSM_ST_5V_SOCK])
    else $error("5v capability not one");
  AST_ST_RSVD: assert property (@(posedge CLK) disable iff (!rst_n)
    REQ.sel && !REQ.wr && REQ.addr == `SSM_OFS_STATE |=> RDATA[`SSM_ST_5V_SOCK-1:`SSM_ST_CARD_HI+1] == 14'h0000)
    else $error("state reserved bits not zero");
  AST_LV_SOCK: assert property (@(posedge CLK) disable iff (!rst_n)
    REQ.sel && !REQ.wr && REQ.addr == `SSM_OFS_STATE && sock_ov_reg == 2'h0 |=> RDATA[31:30] == 2'h0)
    else $error("low voltage capability set unforced");
  AST_BADVCC: assert property (@(posedge CLK) disable iff (!rst_n)
    sock.bad_vcc && !ctx_clear |=> badvcc_reg)
    else $error("invalid supply flag not set");
  AST_DLOST: assert property (@(posedge CLK) disable iff (!rst_n)
    sock.data_lost && !ctx_clear |=> dlost_reg)
    else $error("data loss flag not set");
  AST_PWR_ST: assert property (@(posedge CLK) disable iff (!rst_n)
    REQ.sel && !REQ.wr && REQ.addr == `SSM_OFS_STATE |=> RDATA[`SSM_ST_PWR] == $past(sock.powered, 2))
    else $error("powered state wrong");
  AST_CARD_HOLD: assert property (@(posedge CLK) disable iff (!rst_n)
    !(inserted && !was_in_reg) && !wr_force && !ctx_clear |=> $stable(card_v_reg))
    else $error("card supply info changed between insertions");

  // ==========================================================
  // Cover points
  COV_IRQ: cover property (@(posedge CLK) disable iff (!rst_n) $rose(SOCKET_CHANGE_INTERRUPT));
  COV_CD_IRQ: cover property (@(posedge CLK) disable iff (!rst_n) mask_reg == 4'h6 && SOCKET_CHANGE_INTERRUPT);
  COV_INSERT: cover property (@(posedge CLK) disable iff (!rst_n) inserted && !was_in_reg);
  COV_CLEAR: cover property (@(posedge CLK) disable iff (!rst_n) wr_event && event_reg != 4'h0);
endmodule // ssm_socket_regs

// ### tb/ssm_card_model.sv
// ==========================================
// Card side of the socket
module ssm_card_model
  import ssm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       present,
  input  wire logic [3:0] volts,
  input  wire logic       sts,
  input  wire logic       cb,
  input  wire logic [3:0] ctl,
  output ssm_sock_t       sock
);
  timeunit 1ns;
  timeprecision 1ns;
  initial sock = 12'hC00;
  always @(posedge clk) begin
    sock.cd1_n      <= #10 ~present;
    // Second contact mates a cycle late, as on a real insertion
    sock.cd2_n      <= #10 sock.cd1_n;
    sock.sts_chg    <= #10 present & sts;
    sock.cardbus    <= #10 cb;
    // Sense lines float once the card leaves
    sock.card_volts <= #10 present ? volts : ~sock.card_volts;
    {sock.powered, sock.interrogating, sock.bad_vcc, sock.data_lost} <= #10 ctl;
  end
endmodule // ssm_card_model

// ### tb/test_socket_status_mask_and_state.sv
`include "ssm_regs.svh"
module test_socket_status_mask_and_state;
  import ssm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Signals
  logic        clk = 0, nrst = 0, global_reset_in_n = 1, pci_bus_reset_in_n = 1, pme = 0, ovr = 0;
  logic        present = 0, sts = 0, cb = 0, irq;
  logic [3:0]  volts = 0, ctl = 0;
  logic [31:0] rdata, s = 32'h0000_ba61;
  logic [63:0] ent, expq[$];
  logic        rd_q = 0;
  ssm_req_t    req = '0;
  ssm_sock_t   sock;
  int          error_cnt = 0, checks_done = 0, cyc = 0;
  always #50 clk = ~clk;
  ssm_card_model u_ssm_card_model (.clk(clk), .present(present), .volts(volts), .sts(sts), .cb(cb),
                                   .ctl(ctl), .sock(sock));
  ssm_socket_regs u_ssm_socket_regs (.CLK(clk), .NRST(nrst), .GLOBAL_RESET_IN_N(global_reset_in_n),
    .PCI_BUS_RESET_IN_N(pci_bus_reset_in_n), .PME_ENABLE(pme), .SOCKET_5V_OVERRIDE(ovr), .REQ(req), .SOCK(sock),
    .RDATA(rdata), .SOCKET_CHANGE_INTERRUPT(irq));
  // ==========================================
  // Tasks
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req = '{1'b1, 1'b1, a, d};
    tick(1);
    req.sel = 0;
    // Let an edge pass idle so a following call never re-raises sel in the same time step
    tick(1);
  endtask
  // Read result is noted now and compared by the monitor one cycle on
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    req = '{1'b1, 1'b0, a, 32'h0000_0000};
    expq.push_back({e, m});
    tick(1);
    req.sel = 0;
    tick(1);
  endtask
  task automatic pulse(input logic g);
    if (g) global_reset_in_n = 0;
    else pci_bus_reset_in_n = 0;
    tick(6);
    global_reset_in_n = 1;
    pci_bus_reset_in_n = 1;
    tick(6);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // Monitor and watchdog
  always @(posedge clk) rd_q <= req.sel & ~req.wr;
  always @(negedge clk) if (rd_q === 1'b1) begin
    ent = expq.pop_front();
    chk("rdata", rdata & ent[31:0], ent[63:32] & ent[31:0]);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ==========================================
  // Scenarios
  initial begin
    tick(3);
    nrst = 1;
    tick(3);
    rd(`SSM_OFS_MASK, 0, '1);
    rd(`SSM_OFS_STATE, 32'h3000_0006, 32'hFFFF_FFBF);
    rd(8'h14, 0, '1);
    for (int i = 0; i < 4; i++) begin
      s = lfsr(s);
      wr(`SSM_OFS_MASK, s);
      rd(`SSM_OFS_MASK, s & 32'h0000_000F, '1);
    end
    wr(`SSM_OFS_MASK, 0);
    ovr = 1;
    tick(5);
    rd(`SSM_OFS_STATE, 0, 32'h1000_0000);
    ovr = 0;
    $display("test reset and mask done");
    volts = s[7:4];
    ctl = 4'h4;
    present = 1;
    tick(8);
    rd(`SSM_OFS_STATE, 32'h0000_0006, 32'h0000_0006);
    ctl = 0;
    tick(8);
    rd(`SSM_OFS_STATE, 32'(volts) << 10, 32'h0000_3C06);
    volts = ~volts;
    tick(8);
    rd(`SSM_OFS_STATE, 32'(~volts) << 10, 32'h0000_3C00);
    rd(`SSM_OFS_EVENT, 32'h0000_0006, 32'h0000_0006);
    chk("irq_masked", 32'(irq), 0);
    wr(`SSM_OFS_EVENT, 0);
    rd(`SSM_OFS_EVENT, 32'h0000_0006, 32'h0000_0006);
    wr(`SSM_OFS_EVENT, 32'h0000_000F);
    rd(`SSM_OFS_EVENT, 0, '1);
    $display("test insertion done");
    for (int i = 0; i < 4; i++) begin
      wr(`SSM_OFS_MASK, 32'(i) << 1);
      present = ~present;
      tick(8);
      chk("irq_cd", 32'(irq), 32'(i == 3));
      wr(`SSM_OFS_EVENT, 32'h0000_000F);
      tick(3);
      chk("irq_clr", 32'(irq), 0);
    end
    wr(`SSM_OFS_MASK, 32'h0000_0008);
    ctl = 4'h8;
    tick(8);
    chk("irq_pwr", 32'(irq), 1);
    rd(`SSM_OFS_STATE, 32'h0000_0008, 32'h0000_0008);
    wr(`SSM_OFS_EVENT, 32'h0000_000F);
    wr(`SSM_OFS_MASK, 32'h0000_0001);
    for (int i = 0; i < 2; i++) begin
      cb = (i == 0);
      tick(4);
      // Card kind is only taken at insertion or on a CVSTEST force write, so force one after swapping the card kind
      wr(`SSM_OFS_FORCE, 32'h0000_4000);
      sts = 1;
      tick(8);
      chk("irq_sts_up", 32'(irq), 1);
      rd(`SSM_OFS_STATE, 32'h0000_0001, 32'h0000_0001);
      wr(`SSM_OFS_EVENT, 32'h0000_000F);
      sts = 0;
      tick(8);
      chk("irq_sts_dn", 32'(irq), 32'(i == 1));
      wr(`SSM_OFS_EVENT, 32'h0000_000F);
    end
    $display("test events done");
    ctl = 4'hB;
    tick(8);
    rd(`SSM_OFS_STATE, 32'h0000_0300, 32'h0000_0300);
    wr(`SSM_OFS_FORCE, 32'hC000_3C00);
    tick(2);
    rd(`SSM_OFS_STATE, 32'hF000_3C00, 32'hF000_3C00);
    wr(`SSM_OFS_MASK, 32'h0000_0009);
    pme = 1;
    tick(4);
    pulse(0);
    rd(`SSM_OFS_MASK, 32'h0000_0009, '1);
    pulse(1);
    rd(`SSM_OFS_MASK, 0, '1);
    pme = 0;
    wr(`SSM_OFS_MASK, 32'h0000_0009);
    tick(4);
    pulse(0);
    rd(`SSM_OFS_MASK, 0, '1);
    tick(2);
    $display("test flags and resets done");
    end_of_test();
  end
endmodule // test_socket_status_mask_and_state
